// File: dcsf_pkg.sv
// constants shared by the 9-bit synchronous fifo block
// assumes a single clock for both ports and an 8-bit apb address
`default_nettype none
package dcsf_pkg;
   // ------------------------------------------------------------
   // apb register map
   // ------------------------------------------------------------
   localparam logic [7:0] DCSF_STATUS_ADDR = 8'h00;
   localparam logic [7:0] DCSF_EOFS_ADDR   = 8'h04;
   localparam logic [7:0] DCSF_FOFS_ADDR   = 8'h08;
   // status field positions
   localparam int DCSF_ST_EMPTY_BIT  = 0;
   localparam int DCSF_ST_AEMPTY_BIT = 1;
   localparam int DCSF_ST_AFULL_BIT  = 2;
   localparam int DCSF_ST_FULL_BIT   = 3;
   localparam int DCSF_ST_MODE_BIT   = 4;
   localparam int DCSF_ST_SEL_LSB    = 5;
   localparam int DCSF_ST_COUNT_LSB  = 16;
   // ------------------------------------------------------------
   // data and offset layout
   // ------------------------------------------------------------
   localparam int            DCSF_DATA_W    = 9;
   localparam int            DCSF_PART_W    = 8;
   localparam logic [15:0]   DCSF_OFS_RESET = 16'h0007;
   localparam logic [8:0]    DCSF_DATA_RESET = 9'h000;
   // offset register selector, one-hot rotation
   typedef enum logic [3:0] {
      DCSF_SEL_EMPTY_LO = 4'b0001,
      DCSF_SEL_EMPTY_HI = 4'b0010,
      DCSF_SEL_FULL_LO  = 4'b0100,
      DCSF_SEL_FULL_HI  = 4'b1000
   } dcsf_sel_t;
endpackage
`default_nettype wire

// File: dcsf_fifo.sv
// 9-bit synchronous fifo with programmable almost flags
// assumes write and read ports share pclk; enables come from same-clock logic
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - words written and read are nine bits wide
// - storage depth is a parameter between 64 and 8K words
// - second enable pin level during reset picks two-enable or load mode
// - two-enable mode writes when primary low, second high, not full
// - load mode writes with primary enable low and load high when not full
// - no write ever taken while full flag is low
// - accepted words go to consecutive locations in arrival order
// - both read enables low and not empty presents next word
// - reads ignored while empty; output keeps last word read
// - load low with primary low writes selected offset register
// - load low with both read enables low outputs selected offset
// - empty and almost-empty flags update on read clock only
// - full and almost-full flags update on write clock only
// - almost thresholds programmable per word, both default to seven
// - every flag holds a new value at least one cycle
// - reset clears pointers so buffer is empty, empty flag low
// - output enable active low; high only drives read_data_oe low, read_data stays driven
// - offset accesses rotate empty low, empty high, full low, full high
// - rotation continues where it stopped after load goes high again
// - almost-empty low at n or fewer words, high at n plus one
// - almost-full low at depth minus m words, high above m free
module dcsf_fifo
   import dcsf_pkg::*;
#(
   parameter int DEPTH = 64
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        reset_n,
   input  wire logic [8:0]  write_data,
   input  wire logic        write_enable_primary_n,
   input  wire logic        second_write_enable_or_load,
   input  wire logic        read_enable_a_n,
   input  wire logic        read_enable_b_n,
   input  wire logic        output_enable_n,
   output logic      [8:0]  read_data,
   output logic             read_data_oe,
   output logic             empty_flag_n,
   output logic             full_flag_n,
   output logic             almost_empty_flag_n,
   output logic             almost_full_flag_n
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [AW-1:0] OFS_DEF = DCSF_OFS_RESET[AW-1:0];

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [AW-1:0] put_part(input logic [AW-1:0] v,
                                              input logic [7:0] b,
                                              input logic hi);
      logic [15:0] w;
      w = 16'(v);
      if (hi)
         w[15:8] = b;
      else
         w[7:0] = b;
      return w[AW-1:0];
   endfunction
   function automatic logic [7:0] get_part(input logic [AW-1:0] v,
                                           input logic hi);
      logic [15:0] w;
      w = 16'(v);
      return hi ? w[15:8] : w[7:0];
   endfunction
   function automatic dcsf_sel_t next_sel(input dcsf_sel_t s);
      dcsf_sel_t n;
      case (s)
         DCSF_SEL_EMPTY_LO: n = DCSF_SEL_EMPTY_HI;
         DCSF_SEL_EMPTY_HI: n = DCSF_SEL_FULL_LO;
         DCSF_SEL_FULL_LO:  n = DCSF_SEL_FULL_HI;
         default:           n = DCSF_SEL_EMPTY_LO;
      endcase
      return n;
   endfunction
   function automatic logic addr_ok(input logic [7:0] a);
      return (a == DCSF_STATUS_ADDR) || (a == DCSF_EOFS_ADDR) ||
             (a == DCSF_FOFS_ADDR);
   endfunction
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [8:0]    mem [DEPTH];
   logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic [CW-1:0] count_r, count_nxt;
   logic [AW-1:0] eofs_r, eofs_nxt, fofs_r, fofs_nxt;
   dcsf_sel_t     sel_r, sel_nxt;
   logic          two_en_r, two_en_nxt;
   logic [8:0]    rdata_r, rdata_nxt;
   logic          ef_n_r, ef_n_nxt, ff_n_r, ff_n_nxt;
   logic          ae_n_r, ae_n_nxt, af_n_r, af_n_nxt;
   logic [31:0]   prdata_r, prdata_nxt;
   logic          ofs_load, wr_go, rd_go, ofs_wr, ofs_rd, apb_wr;
   logic [7:0]    sel_byte;

   // ------------------------------------------------------------
   // fifo and offset control
   // ------------------------------------------------------------
   always_comb
   begin
      // load control only exists when reset picked programmable flags
      ofs_load = ~two_en_r & ~second_write_enable_or_load;
      // both modes need the second pin high to reach the array;
      // gating on reset_n keeps traffic out during reset
      wr_go  = ~write_enable_primary_n & second_write_enable_or_load &
               ff_n_r & reset_n;
      ofs_wr = ofs_load & ~write_enable_primary_n & reset_n;
      ofs_rd = ofs_load & ~read_enable_a_n & ~read_enable_b_n &
               reset_n;
      rd_go  = ~read_enable_a_n & ~read_enable_b_n & ~ofs_load &
               ef_n_r & reset_n;
      apb_wr = psel & penable & pwrite & addr_ok(paddr);
      case (sel_r)
         DCSF_SEL_EMPTY_LO: sel_byte = get_part(eofs_r, 1'b0);
         DCSF_SEL_EMPTY_HI: sel_byte = get_part(eofs_r, 1'b1);
         DCSF_SEL_FULL_LO:  sel_byte = get_part(fofs_r, 1'b0);
         default:           sel_byte = get_part(fofs_r, 1'b1);
      endcase
      wptr_nxt  = wr_go ? AW'(wptr_r + 1'b1) : wptr_r;
      rptr_nxt  = rd_go ? AW'(rptr_r + 1'b1) : rptr_r;
      count_nxt = CW'(count_r + CW'(wr_go) - CW'(rd_go));
      two_en_nxt = two_en_r;
      sel_nxt    = sel_r;
      eofs_nxt   = eofs_r;
      fofs_nxt   = fofs_r;
      rdata_nxt  = rdata_r;
      if (apb_wr && paddr == DCSF_EOFS_ADDR)
         eofs_nxt = pwdata[AW-1:0];
      else if (apb_wr && paddr == DCSF_FOFS_ADDR)
         fofs_nxt = pwdata[AW-1:0];
      if (ofs_wr)
      begin
         case (sel_r)
            DCSF_SEL_EMPTY_LO: eofs_nxt = put_part(eofs_r, write_data[7:0], 1'b0);
            DCSF_SEL_EMPTY_HI: eofs_nxt = put_part(eofs_r, write_data[7:0], 1'b1);
            DCSF_SEL_FULL_LO:  fofs_nxt = put_part(fofs_r, write_data[7:0], 1'b0);
            default:           fofs_nxt = put_part(fofs_r, write_data[7:0], 1'b1);
         endcase
      end
      // selector is never reset by load going high
      if (ofs_wr || ofs_rd)
         sel_nxt = next_sel(sel_r);
      if (ofs_rd)
         rdata_nxt = {1'b0, sel_byte};
      else if (rd_go)
         rdata_nxt = mem[rptr_r];
      if (!reset_n)
      begin
         two_en_nxt = second_write_enable_or_load;
         wptr_nxt   = '0;
         rptr_nxt   = '0;
         count_nxt  = '0;
         sel_nxt    = DCSF_SEL_EMPTY_LO;
         eofs_nxt   = OFS_DEF;
         fofs_nxt   = OFS_DEF;
         rdata_nxt  = DCSF_DATA_RESET;
      end
      // single clock: count is exact, so no pointer crossing is needed
      ef_n_nxt = (count_nxt != '0);
      ff_n_nxt = (count_nxt != DEPTH_C);
      ae_n_nxt = (count_nxt > CW'(eofs_nxt));
      af_n_nxt = (count_nxt < CW'(DEPTH_C - CW'(fofs_nxt)));
   end

   always_ff @(posedge pclk)
   begin
      if (wr_go)
         mem[wptr_r] <= write_data;
   end

   // flags are registers, so any change lasts a whole cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wptr_r   <= '0;
         rptr_r   <= '0;
         count_r  <= '0;
         eofs_r   <= OFS_DEF;
         fofs_r   <= OFS_DEF;
         sel_r    <= DCSF_SEL_EMPTY_LO;
         two_en_r <= 1'b1;
         rdata_r  <= DCSF_DATA_RESET;
         ef_n_r   <= 1'b0;
         ff_n_r   <= 1'b1;
         ae_n_r   <= 1'b0;
         af_n_r   <= 1'b1;
      end
      else
      begin
         wptr_r   <= wptr_nxt;
         rptr_r   <= rptr_nxt;
         count_r  <= count_nxt;
         eofs_r   <= eofs_nxt;
         fofs_r   <= fofs_nxt;
         sel_r    <= sel_nxt;
         two_en_r <= two_en_nxt;
         rdata_r  <= rdata_nxt;
         ef_n_r   <= ef_n_nxt;
         ff_n_r   <= ff_n_nxt;
         ae_n_r   <= ae_n_nxt;
         af_n_r   <= af_n_nxt;
      end
   end

   // ------------------------------------------------------------
   // apb slave, zero wait states
   // ------------------------------------------------------------
   always_comb
   begin
      prdata_nxt = prdata_r;
      // read data captured in setup so access phase answers at once
      if (psel && !penable && !pwrite)
      begin
         prdata_nxt = '0;
         if (paddr == DCSF_STATUS_ADDR)
         begin
            prdata_nxt[DCSF_ST_EMPTY_BIT]  = ef_n_r;
            prdata_nxt[DCSF_ST_AEMPTY_BIT] = ae_n_r;
            prdata_nxt[DCSF_ST_AFULL_BIT]  = af_n_r;
            prdata_nxt[DCSF_ST_FULL_BIT]   = ff_n_r;
            prdata_nxt[DCSF_ST_MODE_BIT]   = two_en_r;
            prdata_nxt[DCSF_ST_SEL_LSB +: 4] = sel_r;
            prdata_nxt[DCSF_ST_COUNT_LSB +: CW] = count_r;
         end
         else if (paddr == DCSF_EOFS_ADDR)
            prdata_nxt[AW-1:0] = eofs_r;
         else if (paddr == DCSF_FOFS_ADDR)
            prdata_nxt[AW-1:0] = fofs_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= '0;
      else
         prdata_r <= prdata_nxt;
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok(paddr);

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   assign read_data           = rdata_r;
   assign read_data_oe        = ~output_enable_n;
   assign empty_flag_n        = ef_n_r;
   assign full_flag_n         = ff_n_r;
   assign almost_empty_flag_n = ae_n_r;
   assign almost_full_flag_n  = af_n_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_read_step;
      rd_go;
   endsequence
   // reset_n empties the buffer, so a full cycle under reset is not a blocked write
   property p_full_blocks;
      (reset_n && !full_flag_n && !rd_go) |=> (count_r == DEPTH_C) && $stable(wptr_r);
   endproperty
   a_full_blocks: assert property (p_full_blocks)
      else $error("write taken while full");
   property p_empty_holds;
      (!empty_flag_n && !ofs_rd && reset_n) |=> $stable(read_data);
   endproperty
   a_empty_holds: assert property (p_empty_holds)
      else $error("output changed on read while empty");
   property p_write_order;
      wr_go |=> (wptr_r == AW'($past(wptr_r) + 1'b1));
   endproperty
   a_write_order: assert property (p_write_order)
      else $error("write pointer did not step by one");
   property p_read_word;
      s_read_step |=> (read_data == $past(mem[rptr_r])) &&
                      (rptr_r == AW'($past(rptr_r) + 1'b1));
   endproperty
   a_read_word: assert property (p_read_word)
      else $error("read did not present next stored word");
   property p_reset_empty;
      !reset_n |=> !empty_flag_n && (count_r == '0) && !almost_empty_flag_n;
   endproperty
   a_reset_empty: assert property (p_reset_empty)
      else $error("reset did not empty the buffer");
   property p_mode_capture;
      !reset_n |=> (two_en_r == $past(second_write_enable_or_load));
   endproperty
   a_mode_capture: assert property (p_mode_capture)
      else $error("mode not taken from pin during reset");
   property p_sel_rotate;
      (reset_n && (ofs_wr || ofs_rd)) |=> (sel_r == next_sel($past(sel_r)));
   endproperty
   a_sel_rotate: assert property (p_sel_rotate)
      else $error("offset selector did not rotate");
   property p_almost_empty;
      $stable(eofs_r) |-> (almost_empty_flag_n == (count_r > CW'(eofs_r)));
   endproperty
   a_almost_empty: assert property (p_almost_empty)
      else $error("almost empty flag wrong for count");
   property p_almost_full;
      $stable(fofs_r) |->
         (almost_full_flag_n == (count_r < CW'(DEPTH_C - CW'(fofs_r))));
   endproperty
   a_almost_full: assert property (p_almost_full)
      else $error("almost full flag wrong for count");
   property p_full_flag;
      full_flag_n == (count_r != DEPTH_C);
   endproperty
   a_full_flag: assert property (p_full_flag)
      else $error("full flag disagrees with count");
endmodule
`default_nettype wire

// File: dcsf_peer.sv
// producer and consumer logic facing the fifo pins
// assumes the bench drives the go inputs by nonblocking assignment on pclk
`timescale 1ns/1ps
`default_nettype none
module dcsf_peer (
   input  wire logic       pclk,
   input  wire logic       reset_n,
   input  wire logic       mode_sel,
   input  wire logic       wr_go,
   input  wire logic       rd_go,
   input  wire logic       ld_go,
   input  wire logic [8:0] data_in,
   output logic      [8:0] write_data,
   output logic            write_enable_primary_n,
   output logic            second_write_enable_or_load,
   output logic            read_enable_a_n,
   output logic            read_enable_b_n
);
   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   logic [8:0] last_r;
   always_ff @(posedge pclk)
   begin
      if (!reset_n)
         last_r <= 9'h0AA;
      else if (wr_go)
         last_r <= data_in;
   end
   // nothing requested while the fifo is held in reset
   assign write_enable_primary_n = ~(wr_go & reset_n);
   assign read_enable_a_n        = ~(rd_go & reset_n);
   assign read_enable_b_n        = ~(rd_go & reset_n);
   // level during reset picks the mode; afterwards ld_go pulls it low,
   // which loads offsets in load mode and blocks writes in two-enable mode
   assign second_write_enable_or_load = !reset_n ? mode_sel : ~ld_go;
   // idle data is not a stale copy, so a false capture shows
   assign write_data = wr_go ? data_in : ~last_r;
endmodule
`default_nettype wire

// File: tb_dual_clock_sync_fifo_9bit.sv
// bench for the 9-bit fifo: flag levels, order, offsets, apb map
// assumes one pclk for both ports, DEPTH 64 and default offsets of 7
`timescale 1ns/1ps
`default_nettype none
module tb_dual_clock_sync_fifo_9bit;
   import dcsf_pkg::*;
   typedef struct {int lvl; logic e, ae, af, f;} dcsf_row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rv;
   logic        reset_n, mode_sel, wr_go, rd_go, ld_go, oe_n, oe, ef, ff, aef, aff;
   logic        wen_n, sec, ra_n, rb_n;
   logic [8:0]  din, wd, rdat;
   int          fail_count, checks, cur, i;
   dcsf_row_t   rows [8] = '{'{0,0,0,1,1}, '{1,1,0,1,1}, '{7,1,0,1,1}, '{8,1,1,1,1},
                             '{56,1,1,1,1}, '{57,1,1,0,1}, '{63,1,1,0,1}, '{64,1,1,0,0}};
   dcsf_fifo #(.DEPTH(64)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .reset_n(reset_n), .write_data(wd),
      .write_enable_primary_n(wen_n), .second_write_enable_or_load(sec),
      .read_enable_a_n(ra_n), .read_enable_b_n(rb_n), .output_enable_n(oe_n),
      .read_data(rdat), .read_data_oe(oe), .empty_flag_n(ef), .full_flag_n(ff),
      .almost_empty_flag_n(aef), .almost_full_flag_n(aff));
   dcsf_peer peer (.pclk(pclk), .reset_n(reset_n), .mode_sel(mode_sel), .wr_go(wr_go),
      .rd_go(rd_go), .ld_go(ld_go), .data_in(din), .write_data(wd),
      .write_enable_primary_n(wen_n), .second_write_enable_or_load(sec),
      .read_enable_a_n(ra_n), .read_enable_b_n(rb_n));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [8:0] pat(input int k);
      return 9'(k * 37 + 5);
   endfunction
   task chk_bit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask
   task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task flags(input logic e, input logic ae, input logic af, input logic f);
      chk_bit("empty_flag_n", e, ef);
      chk_bit("almost_empty_flag_n", ae, aef);
      chk_bit("almost_full_flag_n", af, aff);
      chk_bit("full_flag_n", f, ff);
   endtask
   // back to back writes of the running pattern
   task fill(input int k);
      for (int j = 0; j < k; j++)
      begin
         din <= pat(cur);
         wr_go <= 1'b1;
         @(posedge pclk);
         cur++;
      end
      wr_go <= 1'b0;
      #1;
   endtask
   task put(input logic [8:0] d);
      din <= d;
      wr_go <= 1'b1;
      @(posedge pclk);
      wr_go <= 1'b0;
      #1;
   endtask
   task take(input logic [8:0] e);
      rd_go <= 1'b1;
      @(posedge pclk);
      rd_go <= 1'b0;
      #1;
      chk_word("read_data", 32'(e), 32'(rdat));
   endtask
   // one apb transfer; setup starts right after the next rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wrap_up;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ------------------------------------------------------------
   // clock, watchdog, sequence
   // ------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      #300us;
      fail_count++;
      wrap_up;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, wr_go, rd_go, ld_go, oe_n, reset_n} = '0;
      {paddr, pwdata, din, mode_sel, fail_count, checks, cur} = '0;
      mode_sel = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reset_n <= 1'b1;
      @(posedge pclk);
      #1;
      chk_bit("empty after reset", 1'b0, ef);
      chk_word("read_data after reset", 32'h0, 32'(rdat));
      ld_go <= 1'b1;
      put(9'h0AB);
      chk_bit("second enable low blocks write", 1'b0, ef);
      ld_go <= 1'b0;
      $display("test reset done");
      foreach (rows[r])
      begin
         fill(rows[r].lvl - cur);
         flags(rows[r].e, rows[r].ae, rows[r].af, rows[r].f);
      end
      $display("test levels done");
      put(9'h1FF);
      flags(1'b1, 1'b1, 1'b0, 1'b0);
      rd_go <= 1'b1;
      for (i = 0; i < 64; i++)
      begin
         @(posedge pclk);
         #1;
         chk_word("fifo order", 32'(pat(i)), 32'(rdat));
      end
      @(posedge pclk);
      #1;
      chk_word("word held when empty", 32'(pat(63)), 32'(rdat));
      chk_bit("empty after drain", 1'b0, ef);
      rd_go <= 1'b0;
      oe_n <= 1'b1;
      #1;
      chk_bit("oe released", 1'b0, oe);
      oe_n <= 1'b0;
      #1;
      chk_bit("oe driving", 1'b1, oe);
      $display("test order done");
      apb(1'b0, DCSF_STATUS_ADDR, 32'h0);
      chk_bit("status empty", 1'b0, rv[DCSF_ST_EMPTY_BIT]);
      chk_bit("status mode", 1'b1, rv[DCSF_ST_MODE_BIT]);
      apb(1'b0, DCSF_EOFS_ADDR, 32'h0);
      chk_word("empty offset default", 32'h7, rv);
      chk_bit("mapped no error", 1'b0, err);
      apb(1'b1, DCSF_FOFS_ADDR, 32'h3);
      apb(1'b0, DCSF_FOFS_ADDR, 32'h0);
      chk_word("full offset written", 32'h3, rv);
      apb(1'b0, 8'hFC, 32'h0);
      chk_bit("unmapped error", 1'b1, err);
      $display("test apb done");
      // load mode: latch it during reset, then walk the offset rotation
      mode_sel <= 1'b0;
      reset_n <= 1'b0;
      repeat (2) @(posedge pclk);
      reset_n <= 1'b1;
      ld_go <= 1'b1;
      @(posedge pclk);
      put(9'h002);
      put(9'h000);
      put(9'h005);
      put(9'h000);
      take(9'h002);
      take(9'h000);
      take(9'h005);
      take(9'h000);
      put(9'h002);
      put(9'h000);
      ld_go <= 1'b0;
      @(posedge pclk);
      ld_go <= 1'b1;
      #1;
      take(9'h005);
      ld_go <= 1'b0;
      cur = 0;
      fill(2);
      flags(1'b1, 1'b0, 1'b1, 1'b1);
      fill(1);
      flags(1'b1, 1'b1, 1'b1, 1'b1);
      $display("test offsets done");
      wrap_up;
   end
endmodule
`default_nettype wire
